// >>> rtl/ccp_pwm_top.sv
/*
   Two capture/compare/PWM units with shared time bases, special event
   trigger, relocatable second-unit pin and enhanced four-output PWM.
   Assumes an APB master on SYS_CLK and synchronous pin inputs.
*/
// The APB interface to the registers and the placing of the registers were left to the implementer.
// What this block does
// [RULE_01] each unit's time base follows the timer-select bits of the third timer control
// [RULE_02] both units run together and may share one timer base
// [RULE_03] captures on units using the first timer are suppressed while it counts asynchronously
// [RULE_04] pin-select bit routes unit two to primary pin (1, default) or alternate
// [RULE_05] software sets the direction of whichever pin unit two uses
// [RULE_06] in capture, each unit picks first or third timer independently
// [RULE_07] compare special event resets the timer that unit uses
// [RULE_08] only unit two's special event starts an A/D conversion
// [RULE_09] two PWM units share the period timer, frequency and update
// [RULE_10] enhanced PWM gives outputs A to D with selectable polarity
// [RULE_11] output config field and mode field select output mode and polarity
// [RULE_12] enhanced control copies load only at the period boundary
// [RULE_13] dead-band working copy loads at first duty or period boundary; here duty_bound never fires, so it loads only at the period boundary
// [RULE_14] enhanced PWM waits for timer reset and lags one instruction cycle
// [RULE_15] period is (period register + 1) x 4 Tosc x prescale
// [RULE_16] at period match: clear timer, set output unless 0%, latch duty
// [RULE_17] postscaler only sets the update flag rate, not the frequency
// [RULE_18] software sets pin direction for every enhanced output used
// [RULE_19] output goes inactive when timer with fraction reaches latched duty
`timescale 1ns/1ps
`default_nettype none
module ccp_pwm_top
   import ccp_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CAPTURE1_IN,
   input wire logic CAPTURE2_PRI_IN,
   input wire logic CAPTURE2_ALT_IN,
   output logic PWM_OUT_A,
   output logic PWM_OUT_B,
   output logic PWM_OUT_C,
   output logic PWM_OUT_D,
   output logic SECOND_CCP_UNIT_PRI_OUT,
   output logic SECOND_CCP_UNIT_ALT_OUT,
   output logic AD_START,
   output logic IRQ
);
   logic [1:0] phase_q;
   logic tick;
   logic access;
   logic wr_en;
   logic rd_phase;
   logic [7:0] ctrl1_q;
   logic [5:0] ctrl2_q;
   logic [3:0] t1ctrl_q;
   logic [4:0] t3ctrl_q;
   logic [6:0] t2ctrl_q;
   logic [7:0] period_q;
   logic [6:0] dead_q;
   logic [6:0] dead_work_q;
   logic dead_pend_q;
   logic pin_sel_q;
   logic [STATUS_W-1:0] status_q;
   logic [STATUS_W-1:0] mask_q;
   logic [STATUS_W-1:0] status_set;
   logic [15:0] first_capture_timer;
   logic [15:0] third_capture_timer;
   logic [7:0] pwm_period_timer_q;
   logic [3:0] pre2_q;
   logic [3:0] pre2_lim;
   logic [3:0] post_q;
   logic t2_step;
   logic period_evt;
   logic [3:0] mode [2];
   logic [1:0] dc_bits [2];
   logic [15:0] val_q [2];
   logic [1:0] use_t3;
   logic [1:0] cap_in;
   logic [1:0] ev;
   logic [1:0] special;
   logic [1:0] cmp_out_q;
   logic [9:0] duty_latch_q [2];
   logic [1:0] pwm_lvl_q;
   logic clr1;
   logic clr3;
   out_cfg_t cfg_work_q;
   logic [1:0] pol_work_q;
   logic started_q;
   logic duty_bound;
   logic [3:0] chan;
   logic [3:0] lag_q [INSTR_CLKS-1];
   logic unit2_lvl;
   logic [31:0] rd_data;
   logic rd_hit;

   // instruction-cycle strobe: one SYS_CLK in four
   assign tick = (phase_q == PHASE_LAST);
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) phase_q <= '0;
      else phase_q <= phase_q + 2'h1;
   end

   // APB: one wait state, write and read data at the edge PREADY is seen high
   assign access = PSEL && PENABLE;
   assign rd_phase = access && !PREADY;
   assign wr_en = access && PREADY && PWRITE;

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= rd_phase;
         PSLVERR <= rd_phase && !rd_hit;
         // read data stands only in the cycle PREADY is high
         if (rd_phase && !PWRITE) PRDATA <= rd_data;
         else PRDATA <= '0;
      end
   end

   always_comb begin
      rd_data = '0;
      rd_hit = 1'b1;
      case (PADDR)
         OFF_UNIT1_CTRL: rd_data = 32'(ctrl1_q);
         OFF_UNIT2_CTRL: rd_data = 32'(ctrl2_q);
         OFF_UNIT1_VAL: rd_data = 32'(val_q[0]);
         OFF_UNIT2_VAL: rd_data = 32'(val_q[1]);
         OFF_T1_CTRL: rd_data = 32'(t1ctrl_q);
         OFF_T3_CTRL: rd_data = 32'(t3ctrl_q);
         OFF_T2_CTRL: rd_data = 32'(t2ctrl_q);
         OFF_PERIOD: rd_data = 32'(period_q);
         OFF_FIRST_CAPTURE_TIMER: rd_data = 32'(first_capture_timer);
         OFF_THIRD_CAPTURE_TIMER: rd_data = 32'(third_capture_timer);
         OFF_PWM_PERIOD_TIMER: rd_data = 32'(pwm_period_timer_q);
         OFF_DEAD_BAND: rd_data = 32'(dead_q);
         OFF_PIN_SEL: rd_data = 32'(pin_sel_q);
         OFF_STATUS: rd_data = 32'(status_q);
         OFF_MASK: rd_data = 32'(mask_q);
         OFF_LATCH: rd_data = {5'h00, dead_work_q, duty_latch_q[1], duty_latch_q[0]};
         default: rd_hit = 1'b0;
      endcase
   end

   // configuration registers
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ctrl1_q <= '0;
         ctrl2_q <= '0;
         t1ctrl_q <= '0;
         t3ctrl_q <= '0;
         t2ctrl_q <= '0;
         period_q <= '0;
         dead_q <= '0;
         pin_sel_q <= PIN_SEL_RESET; // RULE_04
         mask_q <= '0;
      end else if (wr_en) begin
         case (PADDR)
            OFF_UNIT1_CTRL: ctrl1_q <= PWDATA[7:0];
            OFF_UNIT2_CTRL: ctrl2_q <= PWDATA[5:0];
            OFF_T1_CTRL: t1ctrl_q <= PWDATA[3:0];
            OFF_T3_CTRL: t3ctrl_q <= PWDATA[4:0];
            OFF_T2_CTRL: t2ctrl_q <= PWDATA[6:0];
            OFF_PERIOD: period_q <= PWDATA[7:0];
            OFF_DEAD_BAND: dead_q <= PWDATA[6:0];
            OFF_PIN_SEL: pin_sel_q <= PWDATA[0];
            OFF_MASK: mask_q <= PWDATA[STATUS_W-1:0];
            default: ;
         endcase
      end
   end

   // time bases for capture and compare
   assign use_t3[0] = t3ctrl_q[T3_SEL1_BIT]; // RULE_01
   assign use_t3[1] = t3ctrl_q[T3_SEL2_BIT]; // RULE_06
   assign clr1 = |(special & ~use_t3); // RULE_07
   assign clr3 = |(special & use_t3); // RULE_07

   ccp_timer #(.W(16)) u_first_timer (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .tick(tick),
      .run(t1ctrl_q[TON_BIT]),
      .presc(t1ctrl_q[TPRE_LSB +: 2]),
      .clear(clr1),
      .load(wr_en && PADDR == OFF_FIRST_CAPTURE_TIMER),
      .load_val(PWDATA[15:0]),
      .count_q(first_capture_timer)
   );

   ccp_timer #(.W(16)) u_third_timer (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .tick(tick),
      .run(t3ctrl_q[TON_BIT]),
      .presc(t3ctrl_q[TPRE_LSB +: 2]),
      .clear(clr3),
      .load(wr_en && PADDR == OFF_THIRD_CAPTURE_TIMER),
      .load_val(PWDATA[15:0]),
      .count_q(third_capture_timer)
   );

   assign mode[0] = ctrl1_q[MODE_LSB +: 4];
   assign mode[1] = ctrl2_q[MODE_LSB +: 4];
   assign dc_bits[0] = ctrl1_q[DC_LSB +: 2];
   assign dc_bits[1] = ctrl2_q[DC_LSB +: 2];
   assign cap_in[0] = CAPTURE1_IN;
   assign cap_in[1] = pin_sel_q ? CAPTURE2_PRI_IN : CAPTURE2_ALT_IN; // RULE_04

   // per-unit capture/compare; both units run side by side
   for (genvar u = 0; u < 2; u++) begin : g_unit // RULE_02
      logic [15:0] base;
      logic prev_q;
      logic match_q;
      logic [3:0] cap_cnt_q;
      logic [3:0] cap_lim;
      logic edge_hit;
      logic blocked;
      logic is_cap;
      logic is_cmp;
      logic match;
      logic cap_fire;
      logic cmp_fire;
      logic [7:0] val_off;

      assign val_off = (u == 0) ? OFF_UNIT1_VAL : OFF_UNIT2_VAL;
      assign base = use_t3[u] ? third_capture_timer : first_capture_timer; // RULE_01
      assign is_cap = (mode[u][3:2] == CLASS_CAP);
      assign is_cmp = (mode[u][3:2] == CLASS_CMP);
      assign edge_hit = (mode[u] == MODE_CAP_FALL) ? (prev_q && !cap_in[u]) : (!prev_q && cap_in[u]);
      assign cap_lim = (mode[u] == MODE_CAP_RISE4) ? CAP_LIM4 :
                       (mode[u] == MODE_CAP_RISE16) ? CAP_LIM16 : 4'h0;
      // the asynchronous first timer cannot be sampled safely
      assign blocked = !use_t3[u] && t1ctrl_q[T1_ASYNC_BIT]; // RULE_03
      assign cap_fire = is_cap && edge_hit && (cap_cnt_q == cap_lim) && !blocked;
      assign match = is_cmp && (base == val_q[u]);
      // fire once on entering the match so a slow prescale cannot repeat it
      assign cmp_fire = match && !match_q;
      assign special[u] = cmp_fire && (mode[u] == MODE_CMP_SPECIAL); // RULE_07
      assign ev[u] = cap_fire || cmp_fire;

      always_ff @(posedge SYS_CLK) begin
         if (SYS_RST) begin
            prev_q <= 1'b0;
            match_q <= 1'b0;
            cap_cnt_q <= '0;
         end else begin
            prev_q <= cap_in[u];
            match_q <= match;
            if (!is_cap) cap_cnt_q <= '0;
            else if (is_cap && edge_hit) cap_cnt_q <= (cap_cnt_q == cap_lim) ? 4'h0 : cap_cnt_q + 4'h1;
         end
      end

      always_ff @(posedge SYS_CLK) begin
         if (SYS_RST) val_q[u] <= '0;
         else if (cap_fire) val_q[u] <= base;
         else if (wr_en && PADDR == val_off) val_q[u] <= PWDATA[15:0];
      end

      always_ff @(posedge SYS_CLK) begin
         if (SYS_RST) cmp_out_q[u] <= 1'b0;
         else if (!is_cmp) cmp_out_q[u] <= 1'b0;
         else if (cmp_fire && mode[u] == MODE_CMP_SET) cmp_out_q[u] <= 1'b1;
         else if (cmp_fire && mode[u] == MODE_CMP_CLR) cmp_out_q[u] <= 1'b0;
      end

      // duty latch and level; both units share one period timer
      always_ff @(posedge SYS_CLK) begin
         if (SYS_RST) begin
            duty_latch_q[u] <= '0;
            pwm_lvl_q[u] <= 1'b0;
         end else if (mode[u][3:2] != CLASS_PWM) begin
            pwm_lvl_q[u] <= 1'b0;
         end else if (period_evt) begin // RULE_09
            duty_latch_q[u] <= {val_q[u][7:0], dc_bits[u]}; // RULE_16
            pwm_lvl_q[u] <= ({val_q[u][7:0], dc_bits[u]} != 10'h000); // RULE_16
         end else if (11'({pwm_period_timer_q, phase_q}) + 11'h001 >= 11'(duty_latch_q[u])) begin
            // the level flop drops as the count steps onto the duty value, not one clock later
            pwm_lvl_q[u] <= 1'b0; // RULE_19
         end
      end
   end

   // period timer: counts instruction cycles through prescale 1, 4 or 16
   assign pre2_lim = (t2ctrl_q[TPRE_LSB +: 2] == 2'b00) ? 4'h0 :
                     (t2ctrl_q[TPRE_LSB +: 2] == 2'b01) ? T2_PRE4_LIM : T2_PRE16_LIM;
   assign t2_step = tick && t2ctrl_q[TON_BIT] && (pre2_q == pre2_lim); // RULE_15
   assign period_evt = t2_step && (pwm_period_timer_q == period_q); // RULE_15

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         pwm_period_timer_q <= '0;
         pre2_q <= '0;
      end else begin
         if (tick && t2ctrl_q[TON_BIT]) pre2_q <= (pre2_q >= pre2_lim) ? 4'h0 : pre2_q + 4'h1;
         if (period_evt) pwm_period_timer_q <= '0; // RULE_16
         else if (t2_step) pwm_period_timer_q <= pwm_period_timer_q + 8'h01;
      end
   end

   // postscaler only paces the update flag
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) post_q <= '0;
      else if (period_evt) post_q <= (post_q == t2ctrl_q[T2_POST_LSB +: 4]) ? 4'h0 : post_q + 4'h1; // RULE_17
   end

   // enhanced control copies and start gating
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         cfg_work_q <= OUT_SINGLE;
         pol_work_q <= '0;
         started_q <= 1'b0;
      end else if (mode[0][3:2] != CLASS_PWM) begin
         started_q <= 1'b0;
      end else if (period_evt) begin
         cfg_work_q <= out_cfg_t'(ctrl1_q[CFG_LSB +: 2]); // RULE_12
         pol_work_q <= mode[0][1:0]; // RULE_11
         started_q <= 1'b1; // RULE_14
      end
   end

   assign duty_bound = pwm_lvl_q[0] && ({pwm_period_timer_q, phase_q} >= duty_latch_q[0]);

   // a new dead-band value waits for the period boundary; duty_bound never fires, as the level is already low when the count reaches duty
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         dead_work_q <= '0;
         dead_pend_q <= 1'b0;
      end else begin
         if (dead_pend_q && (period_evt || duty_bound)) dead_work_q <= dead_q; // RULE_13
         if (wr_en && PADDR == OFF_DEAD_BAND) dead_pend_q <= 1'b1;
         else if (period_evt || duty_bound) dead_pend_q <= 1'b0;
      end
   end

   // active-sense of A..D for each output mode, then polarity
   always_comb begin
      chan = 4'h0;
      if (started_q) begin
         unique case (cfg_work_q) // RULE_10
            OUT_SINGLE: chan = {3'b000, pwm_lvl_q[0]};
            OUT_FULL_FWD: chan = {pwm_lvl_q[0], 2'b00, 1'b1};
            OUT_HALF: chan = {2'b00, !pwm_lvl_q[0], pwm_lvl_q[0]};
            OUT_FULL_REV: chan = {1'b0, 1'b1, pwm_lvl_q[0], 1'b0};
         endcase
      end
      // pol bit 1 inverts A and C, bit 0 inverts B and D
      chan = chan ^ {pol_work_q[0], pol_work_q[1], pol_work_q[0], pol_work_q[1]}; // RULE_10
   end

   // delay line plus output flop gives one instruction cycle of lag
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         for (int i = 0; i < INSTR_CLKS - 1; i++) lag_q[i] <= '0;
      end else begin
         lag_q[0] <= chan; // RULE_14
         for (int i = 1; i < INSTR_CLKS - 1; i++) lag_q[i] <= lag_q[i-1];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         PWM_OUT_A <= 1'b0;
         PWM_OUT_B <= 1'b0;
         PWM_OUT_C <= 1'b0;
         PWM_OUT_D <= 1'b0;
      end else if (mode[0][3:2] == CLASS_PWM) begin
         PWM_OUT_A <= lag_q[INSTR_CLKS-2][0];
         PWM_OUT_B <= lag_q[INSTR_CLKS-2][1];
         PWM_OUT_C <= lag_q[INSTR_CLKS-2][2];
         PWM_OUT_D <= lag_q[INSTR_CLKS-2][3];
      end else begin
         PWM_OUT_A <= cmp_out_q[0];
         PWM_OUT_B <= 1'b0;
         PWM_OUT_C <= 1'b0;
         PWM_OUT_D <= 1'b0;
      end
   end

   // second unit: standard PWM or compare level, steered to one pin
   assign unit2_lvl = (mode[1][3:2] == CLASS_PWM) ? pwm_lvl_q[1] : cmp_out_q[1];
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         SECOND_CCP_UNIT_PRI_OUT <= 1'b0;
         SECOND_CCP_UNIT_ALT_OUT <= 1'b0;
         AD_START <= 1'b0;
      end else begin
         SECOND_CCP_UNIT_PRI_OUT <= pin_sel_q && unit2_lvl; // RULE_04
         SECOND_CCP_UNIT_ALT_OUT <= !pin_sel_q && unit2_lvl; // RULE_04
         AD_START <= special[1]; // RULE_08
      end
   end

   // sticky status, write one to clear; a new event beats the clear
   assign status_set[ST_UNIT1] = ev[0];
   assign status_set[ST_UNIT2] = ev[1];
   assign status_set[ST_PWM_PERIOD_TIMER] = period_evt && (post_q == t2ctrl_q[T2_POST_LSB +: 4]); // RULE_17
   assign status_set[ST_ADC] = special[1]; // RULE_08

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) status_q <= '0;
      else if (wr_en && PADDR == OFF_STATUS) status_q <= (status_q & ~PWDATA[STATUS_W-1:0]) | status_set;
      else status_q <= status_q | status_set;
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) IRQ <= 1'b0;
      else IRQ <= |(status_q & mask_q);
   end
endmodule : ccp_pwm_top
`default_nettype wire

// >>> rtl/ccp_pkg.sv
/*
   Shared constants for the capture/compare/PWM block: register offsets,
   field positions, reset values, unit modes and timing figures.
   Assumes a 32-bit APB slave with byte addresses in the low eight bits.
*/
package ccp_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_UNIT1_CTRL = 8'h00;
   localparam logic [7:0] OFF_UNIT2_CTRL = 8'h04;
   localparam logic [7:0] OFF_UNIT1_VAL = 8'h08;
   localparam logic [7:0] OFF_UNIT2_VAL = 8'h0C;
   localparam logic [7:0] OFF_T1_CTRL = 8'h10;
   localparam logic [7:0] OFF_T3_CTRL = 8'h14;
   localparam logic [7:0] OFF_T2_CTRL = 8'h18;
   localparam logic [7:0] OFF_PERIOD = 8'h1C;
   localparam logic [7:0] OFF_FIRST_CAPTURE_TIMER = 8'h20;
   localparam logic [7:0] OFF_THIRD_CAPTURE_TIMER = 8'h24;
   localparam logic [7:0] OFF_PWM_PERIOD_TIMER = 8'h28;
   localparam logic [7:0] OFF_DEAD_BAND = 8'h2C;
   localparam logic [7:0] OFF_PIN_SEL = 8'h30;
   localparam logic [7:0] OFF_STATUS = 8'h34;
   localparam logic [7:0] OFF_MASK = 8'h38;
   localparam logic [7:0] OFF_LATCH = 8'h3C;

   // unit control fields
   localparam int MODE_LSB = 0;
   localparam int DC_LSB = 4;
   localparam int CFG_LSB = 6;
   // timer control fields
   localparam int TON_BIT = 0;
   localparam int TPRE_LSB = 1;
   localparam int T1_ASYNC_BIT = 3;
   localparam int T3_SEL1_BIT = 3;
   localparam int T3_SEL2_BIT = 4;
   localparam int T2_POST_LSB = 3;
   // status / mask bits
   localparam int ST_UNIT1 = 0;
   localparam int ST_UNIT2 = 1;
   localparam int ST_PWM_PERIOD_TIMER = 2;
   localparam int ST_ADC = 3;
   localparam int STATUS_W = 4;

   localparam logic PIN_SEL_RESET = 1'b1;

   // unit modes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
   localparam logic [1:0] CLASS_CAP = 2'b01;
   localparam logic [1:0] CLASS_CMP = 2'b10;
   localparam logic [1:0] CLASS_PWM = 2'b11;
   localparam logic [3:0] CAP_LIM4 = 4'h3;
   localparam logic [3:0] CAP_LIM16 = 4'hF;

   typedef enum logic [1:0] {
      OUT_SINGLE = 2'b00,
      OUT_FULL_FWD = 2'b01,
      OUT_HALF = 2'b10,
      OUT_FULL_REV = 2'b11
   } out_cfg_t;

   // timing: one instruction cycle is four oscillator periods
   localparam int TOSC_NS = 50;
   localparam int INSTR_NS = 4 * TOSC_NS;
   localparam int INSTR_CLKS = INSTR_NS / TOSC_NS;
   localparam logic [1:0] PHASE_LAST = 2'(INSTR_CLKS - 1);
   localparam logic [3:0] T2_PRE4_LIM = 4'h3;
   localparam logic [3:0] T2_PRE16_LIM = 4'hF;
endpackage : ccp_pkg

// >>> rtl/ccp_timer.sv
/*
   Prescaled up-counter used for the two capture/compare time bases.
   Assumes tick is a one-cycle strobe once per instruction cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module ccp_timer #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic run,
   input wire logic [1:0] presc,
   input wire logic clear,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic [W-1:0] count_q
);
   logic [2:0] pre_q;
   logic [2:0] lim;

   // prescale of 1, 2, 4 or 8
   assign lim = 3'((4'h1 << presc) - 4'h1);

   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= '0;
         pre_q <= '0;
      end else if (load) begin
         count_q <= load_val;
         pre_q <= '0;
      end else if (clear) begin
         count_q <= '0;
         pre_q <= '0;
      end else if (tick && run) begin
         if (pre_q >= lim) begin
            pre_q <= '0;
            count_q <= count_q + W'(1);
         end else begin
            pre_q <= pre_q + 3'h1;
         end
      end
   end
endmodule : ccp_timer
`default_nettype wire

// >>> tb/ccp_pwm_checker.sv
/*
   Checker for ccp_pwm_top: APB handshake timing and output pulse rules.
   Sees only the top ports; attached by the bind at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module ccp_pwm_checker (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic SECOND_CCP_UNIT_PRI_OUT,
   input wire logic SECOND_CCP_UNIT_ALT_OUT,
   input wire logic AD_START
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   ready_wait_a: assert property (PSEL && $rose(PENABLE) |=> PREADY) else $error("ready not one wait state");
   ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
   ready_access_a: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE)) else $error("ready outside access");
   err_ready_a: assert property (PSLVERR |-> PREADY) else $error("slave error without ready");
   err_zero_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("refused read not zero");
   idle_data_a: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data not zero when idle");
   pin_excl_a: assert property (!(SECOND_CCP_UNIT_PRI_OUT && SECOND_CCP_UNIT_ALT_OUT)) else $error("both pins driven");
   ad_pulse_a: assert property (AD_START |=> !AD_START) else $error("conversion start too long");
   cover property (AD_START);
   cover property (PSLVERR);
   cover property ($rose(SECOND_CCP_UNIT_ALT_OUT));
endmodule : ccp_pwm_checker
bind ccp_pwm_top ccp_pwm_checker u_chk (.SYS_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PRDATA, .PREADY,
   .PSLVERR, .SECOND_CCP_UNIT_PRI_OUT, .SECOND_CCP_UNIT_ALT_OUT, .AD_START);
`default_nettype wire

// >>> tb/pwm_load_model.sv
/*
   Load on a PWM pin: measures period and high time between rising edges.
   Assumes the pin is sampled on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
   input wire logic clk,
   input wire logic sig,
   output int per_q,
   output int high_q,
   output int rises_q
);
   int cnt;
   int hi;
   logic last;
   initial begin
      cnt = 0; hi = 0; last = 1'b0; per_q = 0; high_q = 0; rises_q = 0;
   end
   // the pin is taken as an output already set by software on either routing
   // a period is only reported once closed by the next rise
   always @(posedge clk) begin
      last <= sig;
      if (sig === 1'b1 && last !== 1'b1) begin
         per_q <= cnt;
         high_q <= hi;
         rises_q <= rises_q + 1;
         cnt <= 1;
         hi <= 1;
      end else begin
         cnt <= cnt + 1;
         if (sig === 1'b1) hi <= hi + 1;
      end
   end
endmodule : pwm_load_model
`default_nettype wire

// >>> tb/ccp_pwm_top_tb_top.sv
/*
   Self-checking bench for ccp_pwm_top: APB register access, PWM timing,
   enhanced outputs, special event, capture and interrupt. One clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ccp_pwm_top_tb_top;
   import ccp_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, cap1, cap2p, cap2a;
   logic pa, pb, pc, pd, c2p, c2a, ad, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   int fails, total_checks, cycles, ad_n, pa_per, pa_hi, pb_per, pb_hi, c2_per, c2_hi, c2_rise, n0, pa_r, pb_r;
   ccp_pwm_top u_dut (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CAPTURE1_IN(cap1), .CAPTURE2_PRI_IN(cap2p), .CAPTURE2_ALT_IN(cap2a), .PWM_OUT_A(pa), .PWM_OUT_B(pb),
      .PWM_OUT_C(pc), .PWM_OUT_D(pd), .SECOND_CCP_UNIT_PRI_OUT(c2p), .SECOND_CCP_UNIT_ALT_OUT(c2a), .AD_START(ad), .IRQ(irq));
   pwm_load_model u_la (.clk(clk), .sig(pa), .per_q(pa_per), .high_q(pa_hi), .rises_q(pa_r));
   pwm_load_model u_lb (.clk(clk), .sig(pb), .per_q(pb_per), .high_q(pb_hi), .rises_q(pb_r));
   pwm_load_model u_l2 (.clk(clk), .sig(c2p | c2a), .per_q(c2_per), .high_q(c2_hi), .rises_q(c2_rise));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (ad === 1'b1) ad_n <= ad_n + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         test_done;
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   // request held until pready is sampled high, then released for one cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
         output logic e);
      int k;
      k = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      if (k >= 20) chk("pready", 1, 0);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd
   task automatic t_reset;
      logic e;
      rd(OFF_PIN_SEL); chk("pin select reset", 32'h1, r);
      rd(OFF_UNIT1_CTRL); chk("unit1 ctrl reset", 32'h0, r);
      apb(1'b0, 8'hFC, 32'h0, r, e); chk("unmapped error", 1, e);
      chk("unmapped data", 32'h0, r);
      $display("test reset done");
   endtask : t_reset
   task automatic t_pwm2;
      wr(OFF_PERIOD, 32'h9); wr(OFF_UNIT2_VAL, 32'h3); wr(OFF_UNIT2_CTRL, 32'hC); wr(OFF_T2_CTRL, 32'h1);
      cyc(200); chk("pwm2 period", 40, c2_per);
      chk("pwm2 high", 12, c2_hi);
      wr(OFF_PIN_SEL, 32'h0); cyc(100); chk("primary idle", 0, c2p);
      chk("alternate period", 40, c2_per);
      wr(OFF_T2_CTRL, 32'h7B); cyc(500); chk("prescale period", 160, c2_per);
      wr(OFF_UNIT2_VAL, 32'h0); cyc(400); n0 = c2_rise; cyc(400); chk("zero duty", n0, c2_rise);
      wr(OFF_PIN_SEL, 32'h1); wr(OFF_UNIT2_CTRL, 32'h0);
      $display("test pwm2 done");
   endtask : t_pwm2
   task automatic t_enh;
      wr(OFF_T2_CTRL, 32'h1); wr(OFF_UNIT1_VAL, 32'h3); wr(OFF_UNIT1_CTRL, 32'h8C);
      cyc(200); chk("half a high", 12, pa_hi);
      chk("half b high", 28, pb_hi);
      chk("half a period", 40, pa_per);
      wr(OFF_UNIT1_CTRL, 32'h8F); cyc(200); chk("inv a high", 28, pa_hi);
      chk("inv b high", 12, pb_hi);
      wr(OFF_UNIT1_CTRL, 32'h4C); cyc(200); chk("fwd a", 1, pa);
      chk("fwd c", 0, pc);
      wr(OFF_UNIT1_CTRL, 32'h0); wr(OFF_T2_CTRL, 32'h0);
      $display("test enhanced done");
   endtask : t_enh
   task automatic t_special;
      int k;
      wr(OFF_T1_CTRL, 32'h1); wr(OFF_UNIT2_VAL, 32'h5); wr(OFF_MASK, 32'h0); wr(OFF_UNIT2_CTRL, 32'hB);
      n0 = ad_n; k = 0;
      while (ad_n == n0 && k < 300) begin
         cyc(1);
         k++;
      end
      chk("conversion start", 1, ad_n > n0);
      rd(OFF_FIRST_CAPTURE_TIMER); chk("timer1 reset", 1, r[15:0] <= 16'h6);
      chk("irq masked", 0, irq);
      wr(OFF_MASK, 32'h8); cyc(2); chk("irq raised", 1, irq);
      wr(OFF_UNIT2_CTRL, 32'h0); wr(OFF_STATUS, 32'hF); cyc(2); chk("irq cleared", 0, irq);
      wr(OFF_UNIT1_VAL, 32'h5); wr(OFF_UNIT1_CTRL, 32'hB); n0 = ad_n; cyc(300);
      chk("unit1 no conversion", n0, ad_n);
      wr(OFF_UNIT1_CTRL, 32'h0); wr(OFF_MASK, 32'h0);
      $display("test special done");
   endtask : t_special
   task automatic t_capture;
      wr(OFF_T3_CTRL, 32'h11); wr(OFF_UNIT1_CTRL, 32'h5); wr(OFF_UNIT2_CTRL, 32'h5); wr(OFF_STATUS, 32'hF);
      cap1 <= 1'b1; cap2p <= 1'b1; cap2a <= 1'b1; cyc(5);
      rd(OFF_STATUS); chk("both captured", 32'h3, {30'h0, r[1:0]});
      wr(OFF_T1_CTRL, 32'h9); cap1 <= 1'b0; cyc(4); wr(OFF_STATUS, 32'hF);
      cap1 <= 1'b1; cyc(5); rd(OFF_STATUS); chk("async capture blocked", 0, r[0]);
      $display("test capture done");
   endtask : t_capture
   initial begin
      fails = 0; total_checks = 0; cycles = 0; ad_n = 0;
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      cap1 = 1'b0; cap2p = 1'b0; cap2a = 1'b0;
      cyc(6);
      rst <= 1'b0;
      cyc(1);
      t_reset;
      t_pwm2;
      t_enh;
      t_special;
      t_capture;
      test_done;
   end
endmodule : ccp_pwm_top_tb_top
`default_nettype wire
